// File: src/tpg_top.sv
`default_nettype none
module tpg_top #(
	parameter int NIDX = tpg_pkg::NUM_IDX,
	parameter int QWID = tpg_pkg::QW
) (
	input  wire logic                          clk,
	input  wire logic                          arst_n,
	input  wire logic [NIDX-1:0]               pause_req,
	input  wire logic [NIDX-1:0]               pause_enable,
	input  wire logic                          resend_pause,
	input  wire logic [NIDX-1:0][QWID-1:0]     pause_quanta,
	input  wire logic [NIDX-1:0][QWID-1:0]     pause_refresh,
	input  wire logic [tpg_pkg::AW-1:0]        global_pause_dest_addr,
	input  wire logic [tpg_pkg::AW-1:0]        global_pause_src_addr,
	input  wire logic [tpg_pkg::TW-1:0]        global_pause_ethertype,
	input  wire logic [tpg_pkg::TW-1:0]        global_pause_opcode,
	input  wire logic [tpg_pkg::AW-1:0]        priority_pause_dest_addr,
	input  wire logic [tpg_pkg::AW-1:0]        priority_pause_src_addr,
	input  wire logic [tpg_pkg::TW-1:0]        priority_pause_ethertype,
	input  wire logic [tpg_pkg::TW-1:0]        priority_pause_opcode,
	// user frame done report from the data path: one cycle per good frame
	input  wire logic                          user_frame_done,
	input  wire logic [tpg_pkg::AW-1:0]        user_frame_dest_addr,
	input  wire logic                          user_frame_vlan,
	input  wire logic                          user_frame_busy,
	// pause frame beats toward the link
	output logic [tpg_pkg::DW-1:0]             tx_data,
	output logic                               tx_valid,
	output logic                               tx_last,
	output logic [NIDX-1:0]                    pause_sent,
	output tpg_pkg::tpg_stat_t                 stat_tx
);
	////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	logic rst_s1_reg, rst_n_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic is_group(input logic [tpg_pkg::AW-1:0] da);
		is_group = da[tpg_pkg::GROUP_BIT];
	endfunction

	function automatic logic is_bcast(input logic [tpg_pkg::AW-1:0] da);
		is_bcast = &da;
	endfunction

	// lowest set bit, global index taking priority
	function automatic logic [3:0] pick(input logic [NIDX-1:0] v);
		pick = 4'(tpg_pkg::GLOBAL_IX);
		if (!v[tpg_pkg::GLOBAL_IX]) begin
			for (int i = NIDX - 1; i >= 0; i--) begin
				if (v[i]) begin
					pick = 4'(i);
				end
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// refresh timers, one per index
	logic [NIDX-1:0] live;
	logic [NIDX-1:0] expired;
	logic [NIDX-1:0] restart;

	assign live = pause_req & pause_enable;

	for (genvar g = 0; g < NIDX; g++) begin : g_tmr
		tpg_refresh_timer #(
			.W(QWID)
		) u_tmr (
			.clk     (clk),
			.rst_n   (rst_n_reg),
			.active  (live[g]),
			.restart (restart[g]),
			.interval(pause_refresh[g]),
			.expired (expired[g])
		);
	end

	////////////////////////////////////////////////////////////////
	// pending set: new request edges, expiries and resend
	logic [NIDX-1:0] pend_reg, pend_next;
	logic [NIDX-1:0] req_d_reg, req_d_next;
	logic            resend_reg, resend_next;
	tpg_pkg::tpg_state_t state_reg, state_next;
	logic [3:0]      idx_reg, idx_next;
	logic [2:0]      beat_reg, beat_next;
	logic [NIDX-1:0] done_mask;
	logic [NIDX-1:0] pend_set;
	logic            resend_go;

	// resend only acts between frames, so a frame on the wire is never cut
	assign resend_go = resend_reg && !user_frame_busy && (state_reg == tpg_pkg::ST_IDLE);

	// pending update: all set sources gathered first, then ORed in after the clear of the sent index
	always_comb begin
		req_d_next  = live;
		resend_next = resend_reg;
		pend_set = live & ~req_d_reg;
		// expiry requeues
		// the sent index still shows the expiry that queued it, so it is masked
		pend_set = pend_set | (live & expired & ~done_mask);
		if (resend_pause) begin
			resend_next = 1'b1;
		end
		if (resend_go) begin
			pend_set    = pend_set | live;
			resend_next = resend_pause;
		end
		// set wins over clear: a request raised in the done cycle is kept
		pend_next = ((pend_reg & ~done_mask) | pend_set) & pause_enable;
	end

	always_comb begin
		restart = done_mask;
		if (resend_go) begin
			restart = {NIDX{1'b1}};
		end
	end

	////////////////////////////////////////////////////////////////
	// frame sender
	tpg_pkg::tpg_hdr_t hdr;
	logic [QWID-1:0]   quanta;
	logic              glob;
	logic [tpg_pkg::DW-1:0] beat_data;

	assign glob = (idx_reg == 4'(tpg_pkg::GLOBAL_IX));
	assign quanta = pause_quanta[idx_reg];

	// priority payload as 16-bit words: enable vector first, then one time
	// slot per class; only the class being sent gets a nonzero time, so the
	// far end never sees a stale quanta for a class it was not asked about
	logic [NIDX*QWID-1:0] prio_words;

	always_comb begin
		prio_words = '0;
		prio_words[QWID-1:0] = QWID'(1) << idx_reg[2:0];
		prio_words[(32'(idx_reg[2:0]) + 1) * QWID +: QWID] = quanta;
	end

	// header choice per frame kind
	always_comb begin
		if (glob) begin
			hdr.dest_addr = global_pause_dest_addr;
			hdr.src_addr  = global_pause_src_addr;
			hdr.ethertype = global_pause_ethertype;
			hdr.opcode    = global_pause_opcode;
		end else begin
			hdr.dest_addr = priority_pause_dest_addr;
			hdr.src_addr  = priority_pause_src_addr;
			hdr.ethertype = priority_pause_ethertype;
			hdr.opcode    = priority_pause_opcode;
		end
	end

	// beat layout; priority frames carry the enable vector and the one active time slot
	always_comb begin
		beat_data = '0;
		case (beat_reg)
			3'h0: begin
				beat_data = {hdr.src_addr[15:0], hdr.dest_addr};
			end
			3'h1: begin
				beat_data = {hdr.opcode, hdr.ethertype, hdr.src_addr[47:16]};
			end
			3'h2: begin
				if (glob) begin
					beat_data = {48'h000000000000, quanta};
				end else begin
					beat_data = prio_words[tpg_pkg::DW-1:0];
				end
			end
			// the priority payload spills over three beats
			3'h3: begin
				if (!glob) begin
					beat_data = prio_words[2*tpg_pkg::DW-1:tpg_pkg::DW];
				end
			end
			3'h4: begin
				if (!glob) begin
					beat_data[QWID-1:0] = prio_words[NIDX*QWID-1 -: QWID];
				end
			end
			default: begin
				beat_data = '0;    // padding; crc appended downstream
			end
		endcase
	end

	// frame state: waits for the user frame in flight before starting
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		beat_next  = beat_reg;
		done_mask  = '0;
		case (state_reg)
			tpg_pkg::ST_IDLE: begin
				if (pend_reg != '0 && !user_frame_busy) begin
					idx_next   = pick(pend_reg);
					beat_next  = '0;
					state_next = tpg_pkg::ST_SEND;
				end
			end
			tpg_pkg::ST_SEND: begin
				beat_next = beat_reg + 3'h1;
				if (beat_reg == tpg_pkg::LAST_BEAT) begin
					state_next = tpg_pkg::ST_DONE;
				end
			end
			default: begin
				done_mask  = NIDX'(1) << idx_reg;
				state_next = tpg_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// registered outputs
	logic [tpg_pkg::DW-1:0] txd_next;
	logic                   txv_next, txl_next;
	logic [NIDX-1:0]        sent_next;
	tpg_pkg::tpg_stat_t     stat_next;

	always_comb begin
		txv_next  = (state_reg == tpg_pkg::ST_SEND);
		txl_next  = txv_next && (beat_reg == tpg_pkg::LAST_BEAT);
		txd_next  = txv_next ? beat_data : '0;
		sent_next = done_mask;
		stat_next = '0;
		if (state_reg == tpg_pkg::ST_DONE) begin
			stat_next.pause      = glob;
			stat_next.user_pause = !glob;
			stat_next.multicast  = is_group(hdr.dest_addr) && !is_bcast(hdr.dest_addr);
			stat_next.broadcast  = is_bcast(hdr.dest_addr);
			stat_next.unicast    = !is_group(hdr.dest_addr);
		end else if (user_frame_done) begin
			stat_next.unicast   = !is_group(user_frame_dest_addr);
			stat_next.multicast = is_group(user_frame_dest_addr) && !is_bcast(user_frame_dest_addr);
			stat_next.broadcast = is_bcast(user_frame_dest_addr);
			stat_next.vlan      = user_frame_vlan;
		end
	end

	always_ff @(posedge clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pend_reg   <= '0;
			req_d_reg  <= '0;
			resend_reg <= 1'b0;
			state_reg  <= tpg_pkg::ST_IDLE;
			idx_reg    <= '0;
			beat_reg   <= '0;
			tx_data    <= '0;
			tx_valid   <= 1'b0;
			tx_last    <= 1'b0;
			pause_sent <= '0;
			stat_tx    <= '0;
		end else begin
			pend_reg   <= pend_next;
			req_d_reg  <= req_d_next;
			resend_reg <= resend_next;
			state_reg  <= state_next;
			idx_reg    <= idx_next;
			beat_reg   <= beat_next;
			tx_data    <= txd_next;
			tx_valid   <= txv_next;
			tx_last    <= txl_next;
			pause_sent <= sent_next;
			stat_tx    <= stat_next;
		end
	end
endmodule // tpg_top
`default_nettype wire

// File: src/tpg_pkg.sv
`default_nettype none
package tpg_pkg;
	localparam int NUM_IDX   = 9;              // eight priorities plus global
	localparam int GLOBAL_IX = 8;              // index of the global pause entry
	localparam int QW        = 16;             // quanta and refresh width
	localparam int AW        = 48;             // mac address width
	localparam int TW        = 16;             // ethertype / opcode width
	localparam int DW        = 64;             // transmit data path width
	localparam int BEAT_CNT_W = 3;
	// a pause frame is 64 bytes: eight beats of the 64-bit path
	localparam logic [2:0] LAST_BEAT = 3'h7;
	// refresh unit: one tick per clock cycle
	localparam logic [15:0] ZERO_Q = 16'h0000;
	localparam logic [15:0] PRIO_ENABLE_VEC_EN = 16'h0000;
	// bit 0 of the top byte (bits 47:40) of the destination address: group bit
	localparam int GROUP_BIT = 40;

	// header fields of one pause frame kind
	typedef struct packed {
		logic [AW-1:0] dest_addr;
		logic [AW-1:0] src_addr;
		logic [TW-1:0] ethertype;
		logic [TW-1:0] opcode;
	} tpg_hdr_t;

	// one-cycle statistic strobes
	typedef struct packed {
		logic unicast;
		logic multicast;
		logic broadcast;
		logic vlan;
		logic pause;
		logic user_pause;
	} tpg_stat_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_DONE = 2'b10
	} tpg_state_t;
endpackage : tpg_pkg
`default_nettype wire

// File: src/tpg_refresh_timer.sv
`default_nettype none
////////////////////////////////////////////////////////////////
// per-index refresh counter: flags expiry while request held
module tpg_refresh_timer #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         active,
	input  wire logic         restart,
	input  wire logic [W-1:0] interval,
	output logic              expired
);
	logic [W-1:0] cnt_reg, cnt_next;
	logic         exp_reg, exp_next;

	always_comb begin
		cnt_next = cnt_reg;
		exp_next = exp_reg;
		if (!active || restart) begin
			cnt_next = interval;
			exp_next = 1'b0;
		end else if (cnt_reg == '0) begin
			exp_next = 1'b1;   // stays until a restart or a dropped request clears it
		end else begin
			cnt_next = cnt_reg - W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;
endmodule // tpg_refresh_timer
`default_nettype wire

// File: tb/tpg_top_props.sv
`default_nettype none
// watches the pause frame output side of tpg_top
module tpg_top_props #(
	parameter int NIDX = 9,
	parameter int QWID = 16
) (
	input wire logic                      clk,
	input wire logic                      arst_n,
	input wire logic [NIDX-1:0][QWID-1:0] pause_quanta,
	input wire logic [47:0]               global_pause_dest_addr,
	input wire logic [15:0]               global_pause_opcode,
	input wire logic [47:0]               priority_pause_dest_addr,
	input wire logic [63:0]               tx_data,
	input wire logic                      tx_valid,
	input wire logic                      tx_last,
	input wire logic [NIDX-1:0]           pause_sent,
	input wire tpg_pkg::tpg_stat_t        stat_tx
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////
	// frame shape and report: beat offsets count back from the sent pulse
	sent_after_last_a: assert property (tx_last |=> |pause_sent) else $error("no sent pulse after last beat");
	sent_pulse_a: assert property (|pause_sent |-> $onehot(pause_sent) ##1 pause_sent == '0)
		else $error("sent not one pulse");
	frame_len_a: assert property ($rose(tx_valid) |-> (tx_valid && !tx_last)[*7] ##1 (tx_valid && tx_last))
		else $error("frame is not eight beats");
	gstat_a: assert property (|pause_sent |-> stat_tx.pause == pause_sent[8])
		else $error("global pause strobe wrong");
	ustat_a: assert property (|pause_sent |-> stat_tx.user_pause == (|pause_sent[7:0]))
		else $error("prio strobe wrong");
	gdest_a: assert property (pause_sent[8] |-> $past(tx_data[47:0], 8) == global_pause_dest_addr)
		else $error("global dest address wrong");
	pdest_a: assert property (|pause_sent[7:0] |-> $past(tx_data[47:0], 8) == priority_pause_dest_addr)
		else $error("priority dest address wrong");
	gop_a: assert property (pause_sent[8] |-> $past(tx_data[63:48], 7) == global_pause_opcode)
		else $error("opcode wrong");
	gquanta_a: assert property (pause_sent[8] |-> $past(tx_data[15:0], 6) == pause_quanta[8])
		else $error("quanta wrong");
	prio_vector_a: assert property (|pause_sent[7:0] |-> $past(tx_data[15:0], 6) == {8'h00, pause_sent[7:0]})
		else $error("priority enable vector wrong");
	// main scenarios reached
	global_c: cover property (pause_sent[8]);
	prio_c: cover property (|pause_sent[7:0]);
	vlan_c: cover property (stat_tx.vlan);
endmodule // tpg_top_props

bind tpg_top tpg_top_props #(.NIDX(NIDX), .QWID(QWID)) u_props (.clk(clk), .arst_n(arst_n), .pause_quanta(pause_quanta),
	.global_pause_dest_addr(global_pause_dest_addr), .global_pause_opcode(global_pause_opcode),
	.priority_pause_dest_addr(priority_pause_dest_addr), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
	.pause_sent(pause_sent), .stat_tx(stat_tx));
`default_nettype wire

// File: tb/tpg_link_sink.sv
`default_nettype none
// link partner: keeps the beats of the latest frame, counts frames
module tpg_link_sink (
	input  wire logic        clk,
	input  wire logic [63:0] tx_data,
	input  wire logic        tx_valid,
	input  wire logic        tx_last,
	output logic [7:0][63:0] beats,
	output int               frames
);
	timeunit 1ns;
	timeprecision 1ns;
	int idx       = 0;
	int frame_cnt = 0;
	// one driver for the count output
	assign frames = frame_cnt;
	// the link never stalls, so every valid beat is taken
	always @(posedge clk) begin
		if (tx_valid) begin
			beats[idx] <= tx_data;
			idx        <= tx_last ? 0 : idx + 1;
			if (tx_last) begin
				frame_cnt <= frame_cnt + 1;
			end
		end
	end
endmodule // tpg_link_sink
`default_nettype wire

// File: tb/tpg_top_bench.sv
`default_nettype none
module tpg_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk = 0, arst_n = 0, resend = 0, ubusy = 0, udone = 0, uvlan = 0;
	logic [8:0]           req = 9'h000, en = 9'h1FF, sent;
	logic [8:0][15:0]     quanta, refresh;
	logic [47:0]          gda = 48'h0180C2000001, gsa = 48'h0A0B0C0D0E0F, uda = 48'h000000000000;
	logic [47:0]          pda = 48'h001122334455, psa = 48'h00AABBCCDDEE;
	logic [15:0]          get = 16'h8808, gop = 16'h0001, pet = 16'h8809, pop = 16'h0101;
	logic [63:0]          tx_data;
	logic                 tx_valid, tx_last;
	tpg_pkg::tpg_stat_t   stat;
	logic [7:0][63:0]     beats;
	int                   frames, fail_count = 0, tests_run = 0, n;
	initial forever #50 clk = ~clk;
	tpg_top #(.NIDX(9), .QWID(16)) u_dut (.clk(clk), .arst_n(arst_n), .pause_req(req), .pause_enable(en),
		.resend_pause(resend), .pause_quanta(quanta), .pause_refresh(refresh), .global_pause_dest_addr(gda),
		.global_pause_src_addr(gsa), .global_pause_ethertype(get), .global_pause_opcode(gop),
		.priority_pause_dest_addr(pda), .priority_pause_src_addr(psa), .priority_pause_ethertype(pet),
		.priority_pause_opcode(pop), .user_frame_done(udone), .user_frame_dest_addr(uda), .user_frame_vlan(uvlan),
		.user_frame_busy(ubusy), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .pause_sent(sent),
		.stat_tx(stat));
	tpg_link_sink u_sink (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .beats(beats),
		.frames(frames));
	////////////////////////////////////////////////////////////////
	// inputs move 2 ns after the edge so the design never races them
	task automatic tick(int k = 1);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic chk(logic [63:0] got, logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// bounded wait for the next sent pulse
	task automatic wait_sent();
		int k;
		k = 0;
		do begin
			tick();
			k++;
		end while (sent === 9'h000 && k < 300);
		// a pulse found on the very last try is not a timeout
		if (sent === 9'h000) begin
			fail_count++;
			end_of_test();
		end
	endtask
	// one pause frame of index i, header and payload against the inputs
	task automatic chk_frame(int i);
		logic g;
		g = (i == 8);
		wait_sent();
		chk(sent, 9'h001 << i);
		chk(beats[0], g ? {gsa[15:0], gda} : {psa[15:0], pda});
		chk(beats[1], g ? {gop, get, gsa[47:16]} : {pop, pet, psa[47:16]});
		chk(stat, g ? 6'b010010 : 6'b100001);
		if (g)
			chk(beats[2], {48'h000000000000, quanta[8]});
		else begin
			chk(beats[2][15:0], 16'h0001 << i);
			chk(beats[2 + (i + 1) / 4][16 * ((i + 1) % 4) +: 16], quanta[i]);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 9; i++) begin
			quanta[i] = 16'h1000 | 16'(i);
			refresh[i] = 16'hFFFF;
		end
		tick(8);
		arst_n = 1;
		tick(3);
		// global and priority 0 together: global goes first
		req = 9'h101;
		chk_frame(8);
		chk_frame(0);
		req = 9'h000;
		for (int i = 1; i < 8; i++) begin
			tick();
			req = 9'h001 << i;
			chk_frame(i);
			req = 9'h000;
		end
		// disabled index stays silent
		en = 9'h1F7;
		n = frames;
		req = 9'h008;
		tick(40);
		chk(64'(frames), 64'(n));
		req = 9'h000;
		en = 9'h1FF;
		// held global request with a 40-cycle refresh sends a frame every 52 cycles
		refresh[8] = 16'h0028;
		n = frames;
		req = 9'h100;
		tick(200);
		req = 9'h000;
		chk(64'((frames - n) >= 3 && (frames - n) <= 5), 64'h1);
		tick(20);
		refresh[8] = 16'hFFFF;
		// resend waits out a busy user frame
		req = 9'h004;
		chk_frame(2);
		ubusy = 1;
		resend = 1;
		tick();
		resend = 0;
		n = frames;
		tick(30);
		chk(64'(frames), 64'(n));
		ubusy = 0;
		wait_sent();
		chk(sent, 9'h004);
		req = 9'h000;
		// user frame strobes: unicast with tag, multicast, broadcast
		for (int k = 0; k < 3; k++) begin
			tick();
			uda = k == 0 ? 48'h020000000001 : (k == 1 ? 48'h010000000001 : 48'hFFFFFFFFFFFF);
			uvlan = (k == 0);
			udone = 1;
			tick();
			udone = 0;
			chk(stat, k == 0 ? 6'b100100 : (k == 1 ? 6'b010000 : 6'b001000));
			tick();
			chk(stat, 6'b000000);
		end
		end_of_test();
	end
endmodule // tpg_top_bench
`default_nettype wire
